// file: charge_emulation_pkg.sv
// Package with register map, field layout, states and timing for the emulation limit selector
package charge_emulation_pkg;

	// APB register byte addresses
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_LIMIT      = 8'h04;
	localparam logic [7:0] ADDR_CUSTOM_CFG = 8'h08;
	localparam logic [7:0] ADDR_STATUS     = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STAT   = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;
	localparam logic [7:0] ADDR_TIMEOUT    = 8'h18;

	// Control register fields
	localparam int CTRL_MODE_LSB    = 0;
	localparam int CTRL_MODE_W      = 3;
	localparam int CTRL_RETRY_BIT   = 3;
	localparam int CTRL_TMO_EN_BIT  = 4;
	localparam int CTRL_HS_CFG_BIT  = 5;
	localparam int CTRL_VARIANT_BIT = 6;
	localparam int CTRL_LEG_EN_LSB  = 8;
	localparam int CTRL_DCP_EN_BIT  = 15;
	localparam int CTRL_CUST_EN_BIT = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_ff18;

	// Rationing minimum select field in the custom configuration
	localparam int RMIN_LSB = 2;
	localparam int RMIN_MSB = 4;

	// Current limit codes in mA
	localparam int LIMIT_W = 12;
	localparam logic [LIMIT_W-1:0] LIMIT_CC_THRESHOLD_MA = 12'd1680;
	localparam logic [LIMIT_W-1:0] LIMIT_RESET_MA        = 12'd500;

	// Interrupt bits
	localparam int IRQ_ACCEPT = 0;
	localparam int IRQ_NO_HANDSHAKE_FLAG  = 1;
	localparam int IRQ_REJECT = 2;
	localparam int IRQ_W      = 3;

	// Timing, in microseconds, converted at 250 MHz
	localparam int CLK_MHZ          = 250;
	localparam int EM_RESET_US      = 20;
	localparam int EM_RESET_CYCLES  = EM_RESET_US * CLK_MHZ;
	localparam int DISCHARGE_US     = 10;
	localparam int DISCHARGE_CYCLES = DISCHARGE_US * CLK_MHZ;
	localparam logic [31:0] TIMEOUT_RESET_CYCLES = 32'h0001_0000;

	// Active modes
	typedef enum logic [2:0] {
		MODE_PASS = 3'b000,
		MODE_SDP  = 3'b001,
		MODE_CDP  = 3'b010,
		MODE_DCP  = 3'b011,
		MODE_DCE  = 3'b100
	} active_mode_t;

	// Profile slots: 0 DCP, 1..7 legacy 1..7, 8 custom
	localparam int PROF_W      = 4;
	localparam logic [PROF_W-1:0] PROF_DCP    = 4'h0;
	localparam logic [PROF_W-1:0] PROF_LEG2   = 4'h2;
	localparam logic [PROF_W-1:0] PROF_LEG3   = 4'h3;
	localparam logic [PROF_W-1:0] PROF_CUSTOM = 4'h8;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_RESET    = 3'b001,
		ST_SHORT    = 3'b010,
		ST_APPLY    = 3'b011,
		ST_ACCEPTED = 3'b100,
		ST_NO_HANDSHAKE_FLAG    = 3'b101
	} cycle_state_t;

endpackage

// file: charge_emulation_limit_select.sv
// Current-limit mode selector and dedicated emulation cycle controller with APB registers
`timescale 1ns/100ps

module charge_emulation_limit_select #(
	parameter int EM_RESET_COUNT  = charge_emulation_pkg::EM_RESET_CYCLES,
	parameter int DISCHARGE_COUNT = charge_emulation_pkg::DISCHARGE_CYCLES
) (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Port status inputs
	input  wire logic        port_power_enable,
	input  wire logic        current_above_charge_detect,
	// Port control outputs
	output logic             port_switch_closed,
	output logic             bus_discharge,
	output logic             data_line_short_resistor,
	output logic             data_line_signature_on,
	output logic             high_speed_switch_closed,
	output logic             constant_current_limiting,
	output logic [3:0]       applied_profile,
	output logic             irq
);
	import charge_emulation_pkg::*;

	typedef struct packed {
		logic [31:0]         ctrl;
		logic [LIMIT_W-1:0]  limit;
		logic [7:0]          custom_cfg;
		logic [31:0]         timeout;
		logic [IRQ_W-1:0]    irq_stat;
		logic [IRQ_W-1:0]    irq_mask;
		cycle_state_t        state;
		logic [PROF_W-1:0]   prof;
		logic [31:0]         count;
		logic                no_handshake_flag;
		logic                dcp_detected;
		logic                any_enabled;
		logic [31:0]         prdata;
		logic                pready;
		logic                pslverr;
		logic                switch_closed;
		logic                discharge;
		logic                short_on;
		logic                sig_on;
		logic                hs_closed;
		logic                cc;
		logic                irq;
	} state_t;

	state_t r;
	state_t next_r;

	// Decision terms
	active_mode_t                 mode;
	logic                         retry_en;
	logic                         timeout_en;
	logic                         programmable;
	logic                         below_limit;
	logic                         rationing_trip;
	logic [LIMIT_W-1:0]           rationing_min_current;
	logic [2:0]                   rationing_min_current_select;
	logic                         next_cc;
	logic [PROF_W-1:0]            next_prof;
	logic                         wrap;
	logic [PROF_W-1:0]            first_prof;
	logic                         access;
	logic [IRQ_W-1:0]             ev;

	assign rationing_min_current_select = r.custom_cfg[RMIN_MSB:RMIN_LSB];

	// Rationing minimum current table in mA, indexed by the select code
	always_comb begin
		unique case (rationing_min_current_select)
			3'h0: rationing_min_current = 12'd500;
			3'h1: rationing_min_current = 12'd900;
			3'h2: rationing_min_current = 12'd1000;
			3'h3: rationing_min_current = 12'd1200;
			3'h4: rationing_min_current = 12'd1500;
			3'h5: rationing_min_current = 12'd1800;
			3'h6: rationing_min_current = 12'd2000;
			3'h7: rationing_min_current = 12'd2500;
		endcase
	end

	// Profile enable and next-in-order search; custom is last
	function automatic logic prof_enabled(input logic [31:0] c, input logic [PROF_W-1:0] p);
		logic e;
		e = 1'b0;
		if (p == PROF_DCP)
			e = c[CTRL_DCP_EN_BIT];
		else if (p == PROF_CUSTOM)
			e = c[CTRL_CUST_EN_BIT];
		else
			e = c[CTRL_LEG_EN_LSB + int'(p) - 1];
		return e;
	endfunction

	always_comb begin
		next_prof = r.prof;
		wrap      = 1'b1;
		for (int i = 8; i >= 1; i--) begin
			if (int'(r.prof) + i <= int'(PROF_CUSTOM) &&
			    prof_enabled(r.ctrl, PROF_W'(int'(r.prof) + i))) begin
				next_prof = PROF_W'(int'(r.prof) + i);
				wrap      = 1'b0;
			end
		end
	end

	// First enabled slot of a pass; a disabled DCP slot must not fall back to custom
	always_comb begin
		first_prof = PROF_CUSTOM;
		for (int i = 8; i >= 0; i--) begin
			if (prof_enabled(r.ctrl, PROF_W'(i)))
				first_prof = PROF_W'(i);
		end
	end

	// Combinational limit-mode choice
	always_comb begin
		mode           = active_mode_t'(r.ctrl[CTRL_MODE_LSB +: CTRL_MODE_W]);
		retry_en       = r.ctrl[CTRL_RETRY_BIT];
		timeout_en     = r.ctrl[CTRL_TMO_EN_BIT];
		programmable   = r.ctrl[CTRL_VARIANT_BIT];
		below_limit    = r.limit < LIMIT_CC_THRESHOLD_MA;
		rationing_trip = (rationing_min_current < r.limit) ||
		                 (r.limit > LIMIT_CC_THRESHOLD_MA);
		next_cc        = 1'b0;
		unique case (mode)
			MODE_PASS, MODE_SDP: next_cc = 1'b0;
			MODE_CDP, MODE_DCP:  next_cc = below_limit;
			MODE_DCE: begin
				if (r.state == ST_NO_HANDSHAKE_FLAG)
					next_cc = !rationing_trip;
				else if (r.state == ST_ACCEPTED) begin
					if (r.prof == PROF_DCP)
						next_cc = 1'b1;
					else if (programmable)
						next_cc = (r.prof == PROF_LEG2) ? below_limit : !rationing_trip;
					else
						next_cc = (r.prof == PROF_LEG3) ? below_limit : 1'b0;
				end else if (programmable && !timeout_en)
					next_cc = below_limit;
				else
					next_cc = below_limit;
			end
			default: next_cc = 1'b0;
		endcase
	end

	assign access = psel && penable;

	always_comb begin
		next_r         = r;
		ev             = '0;
		next_r.pready  = 1'b0;
		next_r.pslverr = 1'b0;

		// Emulation cycle
		unique case (r.state)
			ST_IDLE: begin
				next_r.switch_closed = (mode != MODE_DCE) && port_power_enable;
				next_r.short_on      = (mode == MODE_DCP);
				next_r.sig_on        = 1'b0;
				next_r.hs_closed     = (mode != MODE_DCP);
				if (mode == MODE_DCE && port_power_enable) begin
					next_r.state = ST_RESET;
					next_r.prof  = PROF_CUSTOM;
					next_r.count = '0;
				end
			end
			ST_RESET: begin
				// Switch open and lines low before each profile
				next_r.switch_closed = 1'b0;
				next_r.short_on      = 1'b0;
				next_r.sig_on        = 1'b0;
				next_r.hs_closed     = 1'b0;
				next_r.discharge     = r.count < 32'(DISCHARGE_COUNT);
				next_r.count         = r.count + 32'h1;
				if (r.count >= 32'(EM_RESET_COUNT - 1)) begin
					next_r.discharge = 1'b0;
					next_r.count     = '0;
					// Start of a pass restarts at the first enabled profile
					if (r.prof == PROF_CUSTOM || wrap)
						next_r.prof = first_prof;
					else
						next_r.prof = next_prof;
					next_r.state = ST_SHORT;
				end
			end
			ST_SHORT: begin
				// Short or signature goes on one cycle ahead of bus voltage
				next_r.short_on = (r.prof == PROF_DCP) || (r.prof == PROF_LEG2) ||
				                  (r.prof == PROF_LEG3);
				next_r.sig_on   = !next_r.short_on;
				next_r.state    = ST_APPLY;
			end
			ST_APPLY: begin
				next_r.switch_closed = 1'b1;
				next_r.count         = r.count + 32'h1;
				// DCP in the cycle always runs its timer
				if ((timeout_en || r.prof == PROF_DCP) && r.count >= r.timeout) begin
					next_r.count = '0;
					if (current_above_charge_detect) begin
						next_r.state        = ST_ACCEPTED;
						next_r.dcp_detected = (r.prof == PROF_DCP);
						ev[IRQ_ACCEPT]      = 1'b1;
					end else begin
						next_r.short_on = 1'b0;
						next_r.sig_on   = 1'b0;
						ev[IRQ_REJECT]  = 1'b1;
						if (wrap && !retry_en) begin
							next_r.state             = ST_NO_HANDSHAKE_FLAG;
							next_r.no_handshake_flag = 1'b1;
							ev[IRQ_NO_HANDSHAKE_FLAG]            = 1'b1;
						end else
							next_r.state = ST_RESET;
					end
				end
			end
			ST_ACCEPTED: begin
				next_r.hs_closed = 1'b0;
			end
			ST_NO_HANDSHAKE_FLAG: begin
				next_r.short_on      = 1'b0;
				next_r.sig_on        = 1'b0;
				next_r.hs_closed     = r.ctrl[CTRL_HS_CFG_BIT];
				next_r.switch_closed = 1'b1;
			end
			default: next_r.state = ST_IDLE;
		endcase

		// Leaving cycle mode or losing power enable aborts the cycle
		if (r.state != ST_IDLE && (mode != MODE_DCE || !port_power_enable)) begin
			next_r.state        = ST_IDLE;
			next_r.dcp_detected = 1'b0;
			next_r.discharge    = 1'b0;
		end

		next_r.cc = next_cc;

		// APB: one wait state per access, unmapped reads zero and errors
		if (access && !r.pready) begin
			next_r.pready = 1'b1;
			next_r.prdata = '0;
			unique case (paddr)
				ADDR_CTRL:       if (pwrite) next_r.ctrl = pwdata;
				                 else next_r.prdata = r.ctrl;
				ADDR_LIMIT:      if (pwrite) next_r.limit = pwdata[LIMIT_W-1:0];
				                 else next_r.prdata = 32'(r.limit);
				ADDR_CUSTOM_CFG: if (pwrite) next_r.custom_cfg = pwdata[7:0];
				                 else next_r.prdata = 32'(r.custom_cfg);
				ADDR_STATUS: begin
					if (!pwrite)
						next_r.prdata = {20'h0, r.prof, 1'b0, r.state,
						                 2'b0, r.dcp_detected, r.no_handshake_flag};
				end
				ADDR_IRQ_STAT: begin
					// Write one to clear; a same-cycle event still sets
					if (pwrite) next_r.irq_stat = r.irq_stat & ~pwdata[IRQ_W-1:0];
					else next_r.prdata = 32'(r.irq_stat);
				end
				ADDR_IRQ_MASK:   if (pwrite) next_r.irq_mask = pwdata[IRQ_W-1:0];
				                 else next_r.prdata = 32'(r.irq_mask);
				ADDR_TIMEOUT:    if (pwrite) next_r.timeout = pwdata;
				                 else next_r.prdata = r.timeout;
				default:         next_r.pslverr = 1'b1;
			endcase
		end
		next_r.irq_stat = next_r.irq_stat | ev;
		next_r.irq      = |(next_r.irq_stat & r.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r          <= '0;
			r.ctrl     <= CTRL_RESET;
			r.limit    <= LIMIT_RESET_MA;
			r.timeout  <= TIMEOUT_RESET_CYCLES;
			r.state    <= ST_IDLE;
			r.hs_closed <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign prdata                    = r.prdata;
	assign pready                    = r.pready;
	assign pslverr                   = r.pslverr;
	assign port_switch_closed        = r.switch_closed;
	assign bus_discharge             = r.discharge;
	assign data_line_short_resistor  = r.short_on;
	assign data_line_signature_on    = r.sig_on;
	assign high_speed_switch_closed  = r.hs_closed;
	assign constant_current_limiting = r.cc;
	assign applied_profile           = r.prof;
	assign irq                       = r.irq;

endmodule

// file: charge_emulation_sva.sv
// Port checker for the emulation limit selector, bound to its top
`timescale 1ns/100ps
module charge_emulation_sva
	import charge_emulation_pkg::*;
#(
	parameter int EM_RESET_COUNT  = 8,
	parameter int DISCHARGE_COUNT = 4
) (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Port control
	input wire logic        port_switch_closed,
	input wire logic        bus_discharge,
	input wire logic        data_line_short_resistor,
	input wire logic        constant_current_limiting,
	input wire logic [3:0]  applied_profile,
	input wire logic        irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Repeat counts assume the short counts 8 and 4 used by the bench
	apb_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	discharge_open_a: assert property (bus_discharge |-> !port_switch_closed)
		else $error("discharge with switch closed");
	discharge_len_a: assert property ($rose(bus_discharge) |-> bus_discharge[*3])
		else $error("discharge too short");
	reset_open_a: assert property ($rose(bus_discharge) |-> !port_switch_closed[*7])
		else $error("switch reclosed early");
	short_first_a: assert property ($rose(port_switch_closed) && data_line_short_resistor &&
		applied_profile != PROF_DCP |-> $past(data_line_short_resistor))
		else $error("bus applied before short");
	cover property ($rose(irq));
	cover property (pslverr);
	cover property ($rose(data_line_short_resistor));
	cover property ($rose(constant_current_limiting));
endmodule
bind charge_emulation_limit_select charge_emulation_sva #(
	.EM_RESET_COUNT(EM_RESET_COUNT),
	.DISCHARGE_COUNT(DISCHARGE_COUNT)
) u_charge_emulation_sva (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
	.pslverr, .port_switch_closed, .bus_discharge, .data_line_short_resistor,
	.constant_current_limiting, .applied_profile, .irq);

// file: portable_device_model.sv
// Behavioural model of the attached portable device drawing port current
`timescale 1ns/100ps
module portable_device_model #(
	parameter int LAG = 3
) (
	// Clock
	input  wire logic       pclk,
	// Port state seen by the device
	input  wire logic       port_switch_closed,
	input  wire logic [3:0] applied_profile,
	// Behaviour chosen by the bench
	input  wire logic [3:0] accept_profile,
	input  wire logic       want,
	// Current sense
	output logic            current_above_charge_detect
);
	int up = 0;
	// Load current ramps after the bus comes up, so a slow device is modelled by LAG
	always_ff @(posedge pclk) begin
		if (!port_switch_closed || !want || applied_profile != accept_profile) begin
			up <= 0;
		end else if (up < LAG) begin
			up <= up + 1;
		end
	end
	assign current_above_charge_detect = (up >= LAG);
endmodule

// file: charge_emulation_limit_select_tb.sv
// Self-checking bench for the emulation limit selector
`timescale 1ns/100ps
module charge_emulation_limit_select_tb;
	import charge_emulation_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, want, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, lim;
	logic        port_power_enable, current_above_charge_detect, port_switch_closed;
	logic        bus_discharge, data_line_short_resistor, data_line_signature_on;
	logic        high_speed_switch_closed, constant_current_limiting;
	logic [3:0]  applied_profile, accept_profile;
	logic [64:0] notes[$];
	logic [64:0] note;
	int          errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	logic [31:0] en[4]   = '{32'h8200, 32'h8000, 32'h0400, 32'h0800};
	logic [3:0]  acc[4]  = '{4'h2, 4'h0, 4'h3, 4'h4};
	logic [31:0] lims[4] = '{32'd1000, 32'd2000, 32'd1000, 32'd1000};
	logic [3:0]  ccx     = 4'b0111;

	charge_emulation_limit_select #(.EM_RESET_COUNT(8), .DISCHARGE_COUNT(4))
	u_charge_emulation_limit_select (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .port_power_enable, .current_above_charge_detect,
		.port_switch_closed, .bus_discharge, .data_line_short_resistor, .data_line_signature_on,
		.high_speed_switch_closed, .constant_current_limiting, .applied_profile, .irq);
	portable_device_model #(.LAG(3)) u_portable_device_model (.pclk, .port_switch_closed,
		.applied_profile, .accept_profile, .want, .current_above_charge_detect);

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic summarize();
		if (errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Reads leave their expectation in the queue; the monitor below settles it
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m = 32'hffff_ffff, input logic e = 1'b0);
		if (!w) notes.push_back({e, m, d});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= w ? d : 32'h0;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic wirq();
		for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge pclk);
		repeat (2) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, irq});
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && notes.size() > 0) begin
			note = notes.pop_front();
			chk("prdata", note[31:0] & note[63:32], prdata & note[63:32]);
			chk("pslverr", {31'h0, note[64]}, {31'h0, pslverr});
		end
		cycles++;
		if (cycles == 60000) begin
			errors++;
			summarize();
		end
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		port_power_enable = 1'b0;
		accept_profile = 4'h0;
		want = 1'b0;
		lim = $urandom(44828);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		port_power_enable <= 1'b1;
		@(posedge pclk);
		xfer(0, ADDR_CTRL, CTRL_RESET);
		xfer(0, ADDR_LIMIT, 32'd500, 32'hfff);
		xfer(0, ADDR_TIMEOUT, TIMEOUT_RESET_CYCLES);
		xfer(0, 8'h1c, 32'h0, 32'hffff_ffff, 1'b1);
		// Active modes, first two runs straddle the 1.68A boundary
		for (int i = 0; i < 8; i++) begin
			lim = (i < 2) ? 32'd1679 + i : $urandom_range(2400, 1000);
			xfer(1, ADDR_LIMIT, lim);
			xfer(1, ADDR_CTRL, {CTRL_RESET[31:3], 1'b0, 2'(i + 2)});
			repeat (16) @(posedge pclk);
			chk("cc", {31'h0, !i[1] && lim < 1680}, {31'h0, constant_current_limiting});
			if (i[1]) chk("switch", 32'h1, {31'h0, port_switch_closed});
		end
		// Cycle acceptance per profile and variant
		xfer(1, ADDR_TIMEOUT, 32'd40);
		xfer(1, ADDR_IRQ_MASK, 32'h1);
		want <= 1'b1;
		for (int r = 0; r < 4; r++) begin
			xfer(1, ADDR_CTRL, 32'h0);
			accept_profile <= acc[r];
			xfer(1, ADDR_LIMIT, lims[r]);
			xfer(1, ADDR_CTRL, en[r] | 32'h14 | (r < 2 ? 32'h40 : 32'h0));
			wirq();
			chk("cc", {31'h0, ccx[r]}, {31'h0, constant_current_limiting});
			chk("short", {31'h0, ccx[r]}, {31'h0, data_line_short_resistor});
			chk("profile", {28'h0, acc[r]}, {28'h0, applied_profile});
			if (r == 1) chk("hs", 32'h0, {31'h0, high_speed_switch_closed});
			xfer(1, ADDR_IRQ_STAT, 32'h7);
		end
		// No handshake: one profile, no retry, device never draws
		xfer(1, ADDR_CTRL, 32'h0);
		want <= 1'b0;
		xfer(1, ADDR_IRQ_MASK, 32'h2);
		xfer(1, ADDR_CUSTOM_CFG, 32'h0);
		xfer(1, ADDR_CTRL, 32'h174);
		wirq();
		chk("short", 32'h0, {31'h0, data_line_short_resistor});
		chk("sig", 32'h0, {31'h0, data_line_signature_on});
		chk("hs", 32'h1, {31'h0, high_speed_switch_closed});
		chk("cc", 32'h0, {31'h0, constant_current_limiting});
		xfer(1, ADDR_CUSTOM_CFG, 32'h1c);
		chk("cc", 32'h1, {31'h0, constant_current_limiting});
		xfer(1, ADDR_IRQ_MASK, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		xfer(1, ADDR_IRQ_MASK, 32'h2);
		chk("irq", 32'h1, {31'h0, irq});
		xfer(1, ADDR_IRQ_STAT, 32'h2);
		chk("irq", 32'h0, {31'h0, irq});
		xfer(0, ADDR_STATUS, 32'h1, 32'h1);
		repeat (4) @(posedge pclk);
		summarize();
	end
endmodule
